// *** design/bcd_cfg.svh ***
// Encodings, cycle counts and reset values of the decoder
`ifndef BCD_CFG_SVH
`define BCD_CFG_SVH
// Operation
// (RQ1) Nibble 1011 skips next when file bit clear
// (RQ2) Nibble 1010 skips next when file bit set
// (RQ3) 1110 0ccc conditional branch on status flag
// (RQ4) 1110 110s plus second word: absolute call
// (RQ5) 1110 1111 plus second word: absolute jump
// (RQ6) Word 0006h discards stack top, one cycle
// (RQ7) Word 0005h pushes program counter, one cycle
// (RQ8) 0010h/0011h interrupt return, enables re-set
// (RQ9) 0000 1100 kkkk kkkk: return with working_register literal
// (RQ10) Word 0003h enters standby, updates timeout/powerdown
// (RQ11) Taken or PC-changing: second cycle is no-op
// (RQ12) Unconsumed second instruction word executes as no-op
// (RQ13) Nibbles 1001/1000/0111: bit clear, set, toggle
// (RQ14) 1101 0/1 eleven-bit relative jump or call

`define BCD_NIB_SKIP_CLR 4'hB
`define BCD_NIB_SKIP_SET 4'hA
`define BCD_NIB_BIT_CLR 4'h9
`define BCD_NIB_BIT_SET 4'h8
`define BCD_NIB_BIT_TGL 4'h7
`define BCD_NIB_CTRL 4'hE
`define BCD_NIB_REL 4'hD
`define BCD_NIB_SECOND 4'hF
`define BCD_NIB_MISC 4'h0
`define BCD_CALL_CODE 3'h6
`define BCD_JUMP_CODE 4'hF
`define BCD_WORD_NOP 16'h0000
`define BCD_WORD_POP 16'h0006
`define BCD_WORD_PUSH 16'h0005
`define BCD_WORD_STANDBY 16'h0003
`define BCD_IRQ_RET_HI 15'h0008
`define BCD_SUB_RET_HI 15'h0009
`define BCD_LIT_RET_HI 8'h0C
`define BCD_CYC_ONE 2'h1
`define BCD_CYC_TWO 2'h2
`define BCD_RST_CYC 2'h0
`define BCD_RST_ADDR 8'h00
`define BCD_RST_OFFSET 11'h000
`define BCD_RST_TARGET 20'h00000
`endif

// *** design/bcd_pkg.sv ***
// Types shared by the decoder modules
package bcd_pkg;
   typedef enum logic [4:0] {
      BCD_NOP, BCD_BIT_CLR, BCD_BIT_SET, BCD_BIT_TGL, BCD_SKIP_CLR, BCD_SKIP_SET,
      BCD_BRANCH_COND, BCD_REL_JUMP, BCD_REL_CALL, BCD_ABS_CALL, BCD_ABS_JUMP,
      BCD_POP, BCD_PUSH, BCD_IRQ_RET, BCD_LIT_RET, BCD_SUB_RET, BCD_STANDBY,
      BCD_OTHER, BCD_OPERAND, BCD_SQUASH
   } bcd_class_e;
   typedef enum logic [1:0] {ST_EXEC, ST_OPERAND, ST_FLUSH, ST_SKIP} bcd_state_e;
endpackage : bcd_pkg

// *** design/bcd_op_decode.sv ***
// Combinational classifier of one instruction word
`timescale 1ns/100ps
`include "bcd_cfg.svh"
module bcd_op_decode (
   input wire logic [15:0] instr_i,
   input wire logic flag_zero_i,
   input wire logic flag_carry_i,
   input wire logic flag_ovf_i,
   input wire logic flag_neg_i,
   input wire logic file_bit_i,
   output bcd_pkg::bcd_class_e op_class_o,
   output logic cond_true_o,
   output logic two_word_o,
   output logic pc_change_o,
   output logic [10:0] rel_offset_o
);
   logic flag_sel;

   // Flag pair picked by ccc[2:1], polarity by ccc[0]
   always_comb begin
      case (instr_i[10:9])
         2'h0: flag_sel = flag_zero_i;
         2'h1: flag_sel = flag_carry_i;
         2'h2: flag_sel = flag_ovf_i;
         default: flag_sel = flag_neg_i;
      endcase
   end

   always_comb begin
      op_class_o = bcd_pkg::BCD_OTHER;
      cond_true_o = 1'b0;
      rel_offset_o = {{3{instr_i[7]}}, instr_i[7:0]};
      case (instr_i[15:12])
         `BCD_NIB_SKIP_CLR: begin
            op_class_o = bcd_pkg::BCD_SKIP_CLR; // see (RQ1)
            cond_true_o = ~file_bit_i;
         end
         `BCD_NIB_SKIP_SET: begin
            op_class_o = bcd_pkg::BCD_SKIP_SET; // see (RQ2)
            cond_true_o = file_bit_i;
         end
         `BCD_NIB_BIT_CLR: op_class_o = bcd_pkg::BCD_BIT_CLR; // see (RQ13)
         `BCD_NIB_BIT_SET: op_class_o = bcd_pkg::BCD_BIT_SET; // see (RQ13)
         `BCD_NIB_BIT_TGL: op_class_o = bcd_pkg::BCD_BIT_TGL; // see (RQ13)
         `BCD_NIB_CTRL: begin
            if (!instr_i[11]) begin
               op_class_o = bcd_pkg::BCD_BRANCH_COND; // see (RQ3)
               cond_true_o = flag_sel ^ instr_i[8];
            end else if (instr_i[11:9] == `BCD_CALL_CODE) begin
               op_class_o = bcd_pkg::BCD_ABS_CALL; // see (RQ4)
            end else if (instr_i[11:8] == `BCD_JUMP_CODE) begin
               op_class_o = bcd_pkg::BCD_ABS_JUMP; // see (RQ5)
            end
         end
         `BCD_NIB_REL: begin
            op_class_o = instr_i[11] ? bcd_pkg::BCD_REL_CALL : bcd_pkg::BCD_REL_JUMP; // see (RQ14)
            rel_offset_o = instr_i[10:0];
         end
         // A lone second word carries no operation
         `BCD_NIB_SECOND: op_class_o = bcd_pkg::BCD_NOP; // see (RQ12)
         `BCD_NIB_MISC: begin
            if (instr_i == `BCD_WORD_NOP) op_class_o = bcd_pkg::BCD_NOP;
            else if (instr_i == `BCD_WORD_POP) op_class_o = bcd_pkg::BCD_POP; // see (RQ6)
            else if (instr_i == `BCD_WORD_PUSH) op_class_o = bcd_pkg::BCD_PUSH; // see (RQ7)
            else if (instr_i == `BCD_WORD_STANDBY) op_class_o = bcd_pkg::BCD_STANDBY; // see (RQ10)
            else if (instr_i[15:1] == `BCD_IRQ_RET_HI) op_class_o = bcd_pkg::BCD_IRQ_RET; // see (RQ8)
            else if (instr_i[15:1] == `BCD_SUB_RET_HI) op_class_o = bcd_pkg::BCD_SUB_RET;
            else if (instr_i[15:8] == `BCD_LIT_RET_HI) op_class_o = bcd_pkg::BCD_LIT_RET; // see (RQ9)
         end
         default: op_class_o = bcd_pkg::BCD_OTHER;
      endcase
   end

   assign two_word_o = (op_class_o == bcd_pkg::BCD_ABS_CALL) ||
                       (op_class_o == bcd_pkg::BCD_ABS_JUMP);
   assign pc_change_o = (op_class_o == bcd_pkg::BCD_REL_JUMP) ||
                        (op_class_o == bcd_pkg::BCD_REL_CALL) ||
                        (op_class_o == bcd_pkg::BCD_IRQ_RET) ||
                        (op_class_o == bcd_pkg::BCD_LIT_RET) ||
                        (op_class_o == bcd_pkg::BCD_SUB_RET);
endmodule : bcd_op_decode

// *** design/bcd_decoder.sv ***
// Bit and control operation decoder with skip, flush and operand sequencing
`timescale 1ns/100ps
`include "bcd_cfg.svh"
module bcd_decoder (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic flag_zero_i,
   input wire logic flag_carry_i,
   input wire logic flag_ovf_i,
   input wire logic flag_neg_i,
   input wire logic file_bit_i,
   output logic dec_valid_o,
   output bcd_pkg::bcd_class_e op_class_o,
   output logic [2:0] bit_num_o,
   output logic [7:0] file_addr_o,
   output logic access_bank_o,
   output logic [10:0] rel_offset_o,
   output logic [19:0] abs_target_o,
   output logic [7:0] literal_o,
   output logic [1:0] cycles_o,
   output logic taken_o,
   output logic squash_o,
   output logic stack_push_o,
   output logic stack_pop_o,
   output logic fast_save_o,
   output logic fast_restore_o,
   output logic irq_enable_o,
   output logic standby_o,
   output logic to_pd_update_o
);
   logic rst_q1;
   logic rst_n;
   bcd_pkg::bcd_state_e state;
   bcd_pkg::bcd_class_e d_class;
   logic d_cond;
   logic d_two;
   logic d_pc;
   logic [10:0] d_offset;
   logic pend_call;
   logic pend_fast;
   logic [7:0] target_low;
   logic exec;
   logic redirect;

   // Reset is released through two flops so release is clean to clock_i
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   bcd_op_decode u_dec (
      .instr_i(instr_i),
      .flag_zero_i(flag_zero_i),
      .flag_carry_i(flag_carry_i),
      .flag_ovf_i(flag_ovf_i),
      .flag_neg_i(flag_neg_i),
      .file_bit_i(file_bit_i),
      .op_class_o(d_class),
      .cond_true_o(d_cond),
      .two_word_o(d_two),
      .pc_change_o(d_pc),
      .rel_offset_o(d_offset)
   );

   assign exec = instr_valid_i && (state == bcd_pkg::ST_EXEC);
   assign redirect = d_pc || (d_class == bcd_pkg::BCD_BRANCH_COND && d_cond);

   // Sequencing: operand word, flushed prefetch, skipped word
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= bcd_pkg::ST_EXEC;
      end else if (instr_valid_i) begin
         case (state)
            bcd_pkg::ST_EXEC: begin
               if (d_two) state <= bcd_pkg::ST_OPERAND; // see (RQ4) (RQ5)
               else if (redirect) state <= bcd_pkg::ST_FLUSH; // see (RQ11)
               else if ((d_class == bcd_pkg::BCD_SKIP_CLR ||
                         d_class == bcd_pkg::BCD_SKIP_SET) && d_cond) begin
                  state <= bcd_pkg::ST_SKIP; // see (RQ1) (RQ2)
               end
            end
            bcd_pkg::ST_OPERAND: state <= bcd_pkg::ST_EXEC;
            bcd_pkg::ST_FLUSH: state <= bcd_pkg::ST_EXEC;
            // A skipped two-word instruction costs a third cycle
            bcd_pkg::ST_SKIP: state <= d_two ? bcd_pkg::ST_FLUSH : bcd_pkg::ST_EXEC; // see (RQ1)
            default: state <= bcd_pkg::ST_EXEC;
         endcase
      end
   end

   // First word of a two-word instruction, held for its operand
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pend_call <= 1'b0;
         pend_fast <= 1'b0;
         target_low <= `BCD_RST_ADDR;
      end else if (exec && d_two) begin
         pend_call <= (d_class == bcd_pkg::BCD_ABS_CALL);
         pend_fast <= instr_i[8];
         target_low <= instr_i[7:0];
      end
   end

   // Decoded record, one per accepted word
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         dec_valid_o <= 1'b0;
         op_class_o <= bcd_pkg::BCD_NOP;
         bit_num_o <= 3'h0;
         file_addr_o <= `BCD_RST_ADDR;
         access_bank_o <= 1'b0;
         rel_offset_o <= `BCD_RST_OFFSET;
         literal_o <= `BCD_RST_ADDR;
         cycles_o <= `BCD_RST_CYC;
         taken_o <= 1'b0;
         squash_o <= 1'b0;
      end else begin
         dec_valid_o <= instr_valid_i;
         if (instr_valid_i) begin
            bit_num_o <= instr_i[11:9];
            file_addr_o <= instr_i[7:0];
            access_bank_o <= instr_i[8];
            rel_offset_o <= d_offset;
            literal_o <= instr_i[7:0]; // see (RQ9)
            case (state)
               bcd_pkg::ST_EXEC: begin
                  op_class_o <= d_class;
                  taken_o <= redirect || (d_cond && (d_class == bcd_pkg::BCD_SKIP_CLR ||
                             d_class == bcd_pkg::BCD_SKIP_SET));
                  squash_o <= 1'b0;
                  cycles_o <= (d_two || redirect || ((d_class == bcd_pkg::BCD_SKIP_CLR ||
                              d_class == bcd_pkg::BCD_SKIP_SET) && d_cond)) ?
                              `BCD_CYC_TWO : `BCD_CYC_ONE; // see (RQ3) (RQ11)
               end
               bcd_pkg::ST_OPERAND: begin
                  // The operand word is consumed, not executed
                  op_class_o <= bcd_pkg::BCD_OPERAND; // see (RQ12)
                  taken_o <= 1'b0;
                  squash_o <= 1'b0;
                  cycles_o <= `BCD_CYC_ONE;
               end
               default: begin
                  op_class_o <= bcd_pkg::BCD_SQUASH; // see (RQ11)
                  taken_o <= 1'b0;
                  squash_o <= 1'b1;
                  cycles_o <= `BCD_CYC_ONE;
               end
            endcase
         end else begin
            taken_o <= 1'b0;
            squash_o <= 1'b0;
         end
      end
   end

   // Absolute target completes when the operand word arrives
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         abs_target_o <= `BCD_RST_TARGET;
      end else if (instr_valid_i && state == bcd_pkg::ST_OPERAND) begin
         abs_target_o <= {instr_i[11:0], target_low}; // see (RQ4) (RQ5)
      end
   end

   // Stack, interrupt-enable and power-status side effects, one-cycle pulses
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         stack_push_o <= 1'b0;
         stack_pop_o <= 1'b0;
         fast_save_o <= 1'b0;
         fast_restore_o <= 1'b0;
         irq_enable_o <= 1'b0;
         standby_o <= 1'b0;
         to_pd_update_o <= 1'b0;
      end else begin
         stack_push_o <= (exec && (d_class == bcd_pkg::BCD_PUSH ||
                          d_class == bcd_pkg::BCD_REL_CALL)) ||
                         (instr_valid_i && state == bcd_pkg::ST_OPERAND && pend_call); // see (RQ7) (RQ14)
         fast_save_o <= instr_valid_i && state == bcd_pkg::ST_OPERAND && pend_call &&
                        pend_fast; // see (RQ4)
         stack_pop_o <= exec && (d_class == bcd_pkg::BCD_POP || d_class == bcd_pkg::BCD_IRQ_RET ||
                        d_class == bcd_pkg::BCD_LIT_RET ||
                        d_class == bcd_pkg::BCD_SUB_RET); // see (RQ6) (RQ9)
         irq_enable_o <= exec && d_class == bcd_pkg::BCD_IRQ_RET; // see (RQ8)
         fast_restore_o <= exec && d_class == bcd_pkg::BCD_IRQ_RET && instr_i[0]; // see (RQ8)
         standby_o <= exec && d_class == bcd_pkg::BCD_STANDBY; // see (RQ10)
         to_pd_update_o <= exec && d_class == bcd_pkg::BCD_STANDBY; // see (RQ10)
      end
   end

   a_skip_clear_state: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ1)
      exec && d_class == bcd_pkg::BCD_SKIP_CLR && !file_bit_i |=>
      state == bcd_pkg::ST_SKIP && cycles_o == `BCD_CYC_TWO)
      else $error("skip on clear bit not entered");
   a_skip_set_hold: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ2)
      exec && d_class == bcd_pkg::BCD_SKIP_SET && !file_bit_i |=>
      state == bcd_pkg::ST_EXEC && cycles_o == `BCD_CYC_ONE && !to_pd_update_o)
      else $error("skip on set taken with bit clear");
   a_branch_taken_flush: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ3)
      exec && d_class == bcd_pkg::BCD_BRANCH_COND && d_cond ##1 instr_valid_i |=>
      squash_o && op_class_o == bcd_pkg::BCD_SQUASH)
      else $error("taken branch not followed by squashed cycle");
   a_branch_not_taken: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ3)
      exec && d_class == bcd_pkg::BCD_BRANCH_COND && !d_cond |=>
      cycles_o == `BCD_CYC_ONE && !taken_o && state == bcd_pkg::ST_EXEC)
      else $error("untaken branch costs more than one cycle");
   a_call_operand_push: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ4)
      exec && d_class == bcd_pkg::BCD_ABS_CALL ##1 instr_valid_i |=>
      stack_push_o && fast_save_o == $past(pend_fast) &&
      abs_target_o[19:8] == $past(instr_i[11:0]))
      else $error("call operand word mishandled");
   a_jump_no_push: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ5)
      exec && d_class == bcd_pkg::BCD_ABS_JUMP ##1 instr_valid_i |=>
      !stack_push_o && op_class_o == bcd_pkg::BCD_OPERAND && state == bcd_pkg::ST_EXEC)
      else $error("jump operand word mishandled");
   a_pop_single: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ6)
      exec && d_class == bcd_pkg::BCD_POP |=>
      stack_pop_o && !stack_push_o && cycles_o == `BCD_CYC_ONE)
      else $error("pop not a single cycle discard");
   a_push_single: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ7)
      exec && d_class == bcd_pkg::BCD_PUSH |=>
      stack_push_o && !stack_pop_o && cycles_o == `BCD_CYC_ONE)
      else $error("push not a single cycle push");
   a_irq_return: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ8)
      exec && d_class == bcd_pkg::BCD_IRQ_RET |=>
      irq_enable_o && fast_restore_o == $past(instr_i[0]) && cycles_o == `BCD_CYC_TWO)
      else $error("interrupt return effects wrong");
   a_literal_return: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ9)
      exec && d_class == bcd_pkg::BCD_LIT_RET |=>
      literal_o == $past(instr_i[7:0]) && stack_pop_o && state == bcd_pkg::ST_FLUSH)
      else $error("literal return effects wrong");
   a_standby_entry: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ10)
      exec && d_class == bcd_pkg::BCD_STANDBY |=>
      standby_o && to_pd_update_o ##1 !standby_o)
      else $error("standby entry pulse wrong");
   a_rel_call_push: assert property (@(posedge clock_i) disable iff (!rst_n) // see (RQ14)
      exec && d_class == bcd_pkg::BCD_REL_CALL |=>
      stack_push_o && cycles_o == `BCD_CYC_TWO && rel_offset_o == $past(instr_i[10:0]))
      else $error("relative call decode wrong");
endmodule : bcd_decoder

// *** test/bcd_fetch_model.sv ***
// Program memory fetch model that hands instruction words and sampled flags to the decoder
`timescale 1ns/100ps
module bcd_fetch_model (
   output logic instr_valid_o,
   output logic [15:0] instr_o,
   output logic [4:0] flags_o
);
   initial begin
      instr_valid_o = 1'b0;
      instr_o = 16'h0000;
      flags_o = 5'h00;
   end

   // Between fetches the bus shows the inverse of its previous value, so a stale word never looks valid
   task automatic put(input logic v, input logic [15:0] w, input logic [4:0] f);
      instr_valid_o <= v;
      instr_o <= v ? w : ~instr_o;
      flags_o <= v ? f : ~flags_o;
   endtask : put
endmodule : bcd_fetch_model

// *** test/bit_and_control_op_decoder_tb.sv ***
// Self-checking bench of the bit and control operation decoder
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bit_and_control_op_decoder_tb;
   typedef struct {
      bcd_pkg::bcd_class_e cls;
      logic [8:0] p;
      logic [1:0] cyc;
      logic ck;
      logic tm;
      logic [2:0] fk;
      logic [19:0] val;
   } bcd_exp_s;
   logic clock_i, rst_n_i, instr_valid;
   logic [15:0] instr;
   logic [4:0] flags;
   logic dec_valid_o, access_bank_o, taken_o, squash_o, stack_push_o, stack_pop_o;
   logic fast_save_o, fast_restore_o, irq_enable_o, standby_o, to_pd_update_o;
   bcd_pkg::bcd_class_e op_class_o;
   logic [2:0] bit_num_o;
   logic [7:0] file_addr_o, literal_o;
   logic [10:0] rel_offset_o;
   logic [19:0] abs_target_o;
   logic [1:0] cycles_o;
   int n_fail = 0;
   int compares = 0;
   int seed = 32'hFDA1;
   logic sq = 1'b0, sq_skip = 1'b0, opnd = 1'b0, opnd_call, opnd_s, pend_v = 1'b0;
   logic [7:0] opnd_lo;
   bcd_exp_s pend;
   logic [16:0] tbl [0:27] = '{17'h1EC12, 17'h1F345, 17'h1ED34, 17'h10678, 17'h1EF56, 17'h1F9AB,
      17'h1F123, 17'h1EC01, 17'h00000, 17'h1FFFF, 17'h10006, 17'h10005, 17'h10010, 17'h19000,
      17'h10011, 17'h19000, 17'h10013, 17'h19000, 17'h10C5A, 17'h19000, 17'h10003, 17'h10004,
      17'h1D7FF, 17'h18F00, 17'h1DC01, 17'h10000, 17'h10012, 17'h10000};

   bcd_fetch_model u_fetch (.instr_valid_o(instr_valid), .instr_o(instr), .flags_o(flags));

   bcd_decoder dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid), .instr_i(instr),
      .flag_zero_i(flags[0]), .flag_carry_i(flags[1]), .flag_ovf_i(flags[2]),
      .flag_neg_i(flags[3]), .file_bit_i(flags[4]), .dec_valid_o(dec_valid_o),
      .op_class_o(op_class_o), .bit_num_o(bit_num_o), .file_addr_o(file_addr_o),
      .access_bank_o(access_bank_o), .rel_offset_o(rel_offset_o), .abs_target_o(abs_target_o),
      .literal_o(literal_o), .cycles_o(cycles_o), .taken_o(taken_o), .squash_o(squash_o),
      .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o), .fast_save_o(fast_save_o),
      .fast_restore_o(fast_restore_o), .irq_enable_o(irq_enable_o), .standby_o(standby_o),
      .to_pd_update_o(to_pd_update_o)
   );

   // Pulse order: taken, squash, push, pop, fast save, fast restore, irq enable, standby, to/pd
   function automatic bcd_exp_s expect_word(input logic [15:0] w, input logic [4:0] f);
      bcd_exp_s e;
      logic two;
      e = '{cls: bcd_pkg::BCD_OTHER, p: 9'h000, cyc: 2'h1, ck: 1'b1, tm: 1'b1, fk: 3'h0,
         val: {8'h00, w[11:0]}};
      two = (w[15:9] == 7'h76) || (w[15:8] == 8'hEF);
      if (sq || opnd) begin
         e.ck = 1'b0;
         e.tm = 1'b0;
         e.cls = sq ? bcd_pkg::BCD_SQUASH : bcd_pkg::BCD_OPERAND;
         e.p[7] = sq;
         e.p[6] = !sq && opnd_call;
         e.p[4] = !sq && opnd_call && opnd_s;
         e.fk = sq ? 3'h0 : 3'h4;
         e.val = {w[11:0], opnd_lo};
         // A skipped call or jump takes its operand word down with it
         if (sq) sq = sq_skip && two;
         else opnd = 1'b0;
         sq_skip = 1'b0;
         return e;
      end
      case (w[15:12])
         4'hA, 4'hB: begin
            e.cls = w[12] ? bcd_pkg::BCD_SKIP_CLR : bcd_pkg::BCD_SKIP_SET;
            e.p[8] = f[4] ^ w[12];
            e.fk = 3'h1;
            sq_skip = e.p[8];
         end
         4'h7: e.cls = bcd_pkg::BCD_BIT_TGL;
         4'h8: e.cls = bcd_pkg::BCD_BIT_SET;
         4'h9: e.cls = bcd_pkg::BCD_BIT_CLR;
         4'hD: begin
            e.cls = w[11] ? bcd_pkg::BCD_REL_CALL : bcd_pkg::BCD_REL_JUMP;
            e.p[8] = 1'b1;
            e.p[6] = w[11];
            e.fk = 3'h2;
         end
         4'hE: begin
            e.cls = w[11] ? bcd_pkg::BCD_OTHER : bcd_pkg::BCD_BRANCH_COND;
            e.p[8] = !w[11] && (f[w[10:9]] ^ w[8]);
            e.fk = w[11] ? 3'h0 : 3'h2;
            e.val = {9'h000, {3{w[7]}}, w[7:0]};
            e.ck = !w[11] || two;
            e.tm = !w[11];
            if (two) begin
               e.cls = (w[11:8] == 4'hF) ? bcd_pkg::BCD_ABS_JUMP : bcd_pkg::BCD_ABS_CALL;
               e.cyc = 2'h2;
               opnd = 1'b1;
               opnd_call = (w[11:8] != 4'hF);
               opnd_s = w[8];
               opnd_lo = w[7:0];
            end
         end
         4'hF: e.cls = bcd_pkg::BCD_NOP;
         4'h0: begin
            e.ck = 1'b0;
            e.tm = 1'b0;
            if (w[15:2] == 14'h0000 || w == 16'h0005 || w == 16'h0006) begin
               e.ck = 1'b1;
               e.tm = 1'b1;
               e.cls = (w == 16'h0005) ? bcd_pkg::BCD_PUSH : (w == 16'h0006) ? bcd_pkg::BCD_POP :
                  (w == 16'h0003) ? bcd_pkg::BCD_STANDBY : bcd_pkg::BCD_NOP;
               e.p[6] = (w == 16'h0005);
               e.p[5] = (w == 16'h0006);
               e.p[1:0] = {2{w == 16'h0003}};
               if (w == 16'h0001 || w == 16'h0002) e.cls = bcd_pkg::BCD_OTHER;
               if (w == 16'h0001 || w == 16'h0002) e.ck = 1'b0;
            end else if (w[15:2] == 14'h0004 || w[15:8] == 8'h0C) begin
               e.ck = 1'b1;
               e.tm = 1'b1;
               e.cls = w[11] ? bcd_pkg::BCD_LIT_RET :
                  w[1] ? bcd_pkg::BCD_SUB_RET : bcd_pkg::BCD_IRQ_RET;
               e.p[8] = 1'b1;
               e.p[5] = 1'b1;
               e.p[3] = !w[11] && !w[1] && w[0];
               e.p[2] = !w[11] && !w[1];
               e.fk = w[11] ? 3'h3 : 3'h0;
            end
         end
         default: begin
            e.ck = 1'b0;
            e.tm = 1'b0;
         end
      endcase
      if (e.p[8]) e.cyc = 2'h2;
      if (e.p[8]) sq = 1'b1;
      return e;
   endfunction : expect_word

   task automatic chk_rec();
      logic [8:0] pul;
      pul = {taken_o, squash_o, stack_push_o, stack_pop_o, fast_save_o, fast_restore_o,
         irq_enable_o, standby_o, to_pd_update_o};
      `CHK(dec_valid_o, pend_v)
      if (!pend_v) `CHK(pul, 9'h000)
      if (!pend_v) return;
      if (!pend.tm) pul[8] = 1'b0;
      `CHK(op_class_o, pend.cls)
      `CHK(pul, pend.p)
      if (pend.ck) `CHK(cycles_o, pend.cyc)
      case (pend.fk)
         3'h1: `CHK({bit_num_o, access_bank_o, file_addr_o}, pend.val[11:0])
         3'h2: `CHK(rel_offset_o, pend.val[10:0])
         3'h3: `CHK(literal_o, pend.val[7:0])
         3'h4: `CHK(abs_target_o, pend.val)
         default: ;
      endcase
   endtask : chk_rec

   task automatic cyc(input logic v, input logic [15:0] w, input logic [4:0] f);
      @(posedge clock_i);
      u_fetch.put(v, w, f);
      #1;
      chk_rec();
      pend_v = v;
      if (v) pend = expect_word(w, f);
   endtask : cyc

   task automatic end_of_test();
      $display("compares=%0d mismatches=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   initial begin
      repeat (100000) @(posedge clock_i);
      n_fail++;
      $display("run did not finish in time");
      end_of_test();
   end

   initial begin
      logic [31:0] r;
      rst_n_i = 1'b0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) cyc(1'b0, 16'h0000, 5'h00);
      // Each condition code once true and once false, with a word behind it to squash
      for (int i = 0; i < 16; i++) begin
         cyc(1'b1, {5'h1C, i[2:0], i[0], 7'h35}, i[3] ? 5'h0F : 5'h00);
         cyc(1'b1, 16'h9A55, 5'h00);
      end
      $display("test branches done");
      for (int i = 0; i < 4; i++) begin
         cyc(1'b1, {3'h5, i[0], 12'h3C7}, {i[1], 4'h0});
         cyc(1'b1, 16'h8E21, 5'h00);
      end
      // A taken skip over a two-word call must drop both of its words
      cyc(1'b1, 16'hB000, 5'h00);
      cyc(1'b1, 16'hED12, 5'h00);
      cyc(1'b1, 16'hF345, 5'h00);
      cyc(1'b1, 16'h7123, 5'h00);
      $display("test skips done");
      foreach (tbl[i]) cyc(tbl[i][16], tbl[i][15:0], 5'h00);
      $display("test table done");
      for (int i = 0; i < 600; i++) begin
         r = $random(seed);
         cyc(r[31:30] != 2'h0, r[15:0], r[20:16]);
      end
      $display("test random done");
      cyc(1'b0, 16'h0000, 5'h00);
      end_of_test();
   end
endmodule : bit_and_control_op_decoder_tb
